/* hdl/pbec_counter.sv */
/*
 * Pattern bit error counter with clear-on-read byte registers,
 * sticky interrupt status and an Avalon-MM slave with waitrequest.
 * Assumes the error event input is synchronous to clock and lasts one
 * cycle per detected bit error.
 */
`timescale 1ns/10ps

// Summary of operation
// - One 16-bit counter as two byte registers.
// - Count each detected pattern bit error up to 16'hFFFF.
// - Reading upper clears the whole count; reading lower clears the lower byte unless an upper read left a snapshot.
// - Upper register is MSB, lower is LSB.
module pbec_counter (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        pattern_error,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [4:0]  address,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   output logic             interrupt
);

   pbec_pkg::pbec_request_type request;
   pbec_pkg::pbec_state_type   state;
   logic [15:0] count;
   logic [7:0]  lower_snapshot;
   logic        snapshot_valid;
   logic [1:0]  irq_status;
   logic [1:0]  irq_enable;
   logic        accept;
   logic        take;
   logic        read_upper;
   logic        read_lower;
   logic [15:0] next_count;
   logic [31:0] next_readdata;

   assign request = '{read, write, address, writedata};

   // ----------------------------------------------------------------
   // Bus handshake: one wait cycle, then the answer edge.
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= pbec_pkg::pbec_idle;
      end else begin
         case (state)
            pbec_pkg::pbec_idle: begin
               if (request.read || request.write) begin
                  state <= pbec_pkg::pbec_answer;
               end
            end
            pbec_pkg::pbec_answer: state <= pbec_pkg::pbec_done;
            pbec_pkg::pbec_done:   state <= pbec_pkg::pbec_idle;
            default:               state <= pbec_pkg::pbec_idle;
         endcase
      end
   end

   // Writes land in the answer state, where waitrequest is low. Reads clear and
   // capture at the accepting edge, the same edge that latches readdata, so an
   // error arriving during the wait cycle is neither lost nor split across bytes.
   assign accept     = (state == pbec_pkg::pbec_idle) && (request.read || request.write);
   assign take       = (state == pbec_pkg::pbec_answer);
   assign read_upper = accept && request.read
                       && request.address == 5'(pbec_pkg::addr_count_upper);
   assign read_lower = accept && request.read
                       && request.address == 5'(pbec_pkg::addr_count_lower);

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !(state == pbec_pkg::pbec_idle && (read || write));
      end
   end

   // ----------------------------------------------------------------
   // Counter
   // ----------------------------------------------------------------
   always_comb begin
      next_count = count;
      if (read_upper) begin
         next_count = 16'h0000;
      end else if (read_lower && !snapshot_valid) begin
         next_count[7:0] = 8'h00;
      end
      // Saturation is judged on the value after any clear, so a read that
      // clears the count and meets an error at full scale still counts that error.
      if (pattern_error && next_count != 16'hFFFF) begin
         next_count = next_count + 16'h0001;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= pbec_pkg::count_reset;
      end else begin
         count <= next_count;
      end
   end

   // Upper read moves the whole count out, so lower reads the frozen byte.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lower_snapshot <= pbec_pkg::byte_reset;
         snapshot_valid <= 1'b0;
      end else if (read_upper) begin
         lower_snapshot <= count[7:0];
         snapshot_valid <= 1'b1;
      end else if (read_lower) begin
         lower_snapshot <= pbec_pkg::byte_reset;
         snapshot_valid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Interrupts: error seen, counter reached 16'hFFFE.
   // ----------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         irq_status <= pbec_pkg::irq_reset;
         irq_enable <= pbec_pkg::irq_reset;
      end else begin
         if (take && request.write && request.address == pbec_pkg::addr_irq_clear) begin
            irq_status <= irq_status & ~request.writedata[1:0];
         end
         if (take && request.write
             && request.address == 5'(pbec_pkg::addr_irq_enable)) begin
            irq_enable <= request.writedata[1:0];
         end
         // Set wins over a clear in the same cycle.
         if (pattern_error) begin
            irq_status[pbec_pkg::irq_error_bit] <= 1'b1;
         end
         if (pattern_error && next_count == 16'hFFFE) begin
            irq_status[pbec_pkg::irq_wrap_bit] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         interrupt <= 1'b0;
      end else begin
         interrupt <= |(irq_status & irq_enable);
      end
   end

   // ----------------------------------------------------------------
   // Read data, registered in the wait cycle so it stands at the answer.
   // ----------------------------------------------------------------
   always_comb begin
      next_readdata = pbec_pkg::unmapped_data;
      case (request.address)
         5'(pbec_pkg::addr_count_upper): next_readdata = {24'h000000, count[15:8]};
         5'(pbec_pkg::addr_count_lower):
            next_readdata = {24'h000000, snapshot_valid ? lower_snapshot : count[7:0]};
         5'(pbec_pkg::addr_irq_status):  next_readdata = {30'h00000000, irq_status};
         5'(pbec_pkg::addr_irq_enable):  next_readdata = {30'h00000000, irq_enable};
         default:                        next_readdata = pbec_pkg::unmapped_data;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         readdata <= pbec_pkg::unmapped_data;
      end else begin
         readdata <= next_readdata;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_count_step;
      @(posedge clock) disable iff (rst)
         pattern_error && !read_upper && !read_lower && count != 16'hFFFF
         |=> count == $past(count) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count missed an error");

   property p_upper_clears;
      @(posedge clock) disable iff (rst)
         read_upper |=> count == {15'h0000, $past(pattern_error)};
   endproperty
   a_upper_clears: assert property (p_upper_clears) else $error("upper read kept count");

   property p_snapshot;
      @(posedge clock) disable iff (rst)
         read_upper |=> lower_snapshot == $past(count[7:0]) && snapshot_valid;
   endproperty
   a_snapshot: assert property (p_snapshot) else $error("lower byte not captured");

   property p_upper_data;
      @(posedge clock) disable iff (rst)
         state == pbec_pkg::pbec_idle && read
         && address == 5'(pbec_pkg::addr_count_upper)
         |=> readdata[7:0] == $past(count[15:8]) && readdata[31:8] == 24'h000000;
   endproperty
   a_upper_data: assert property (p_upper_data) else $error("upper byte wrong");

   property p_lower_release;
      @(posedge clock) disable iff (rst)
         read_lower |=> !snapshot_valid;
   endproperty
   a_lower_release: assert property (p_lower_release) else $error("snapshot not released");

   property p_wait_one;
      @(posedge clock) disable iff (rst)
         state == pbec_pkg::pbec_idle && (read || write) |=> !waitrequest ##1 waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("waitrequest timing wrong");

   property p_irq;
      @(posedge clock) disable iff (rst)
         pattern_error && irq_enable[0] |=> ##1 interrupt;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_lower_data;
      @(posedge clock) disable iff (rst)
         snapshot_valid && state == pbec_pkg::pbec_idle && read
         && address == 5'(pbec_pkg::addr_count_lower)
         |=> readdata[7:0] == $past(lower_snapshot);
   endproperty
   a_lower_data: assert property (p_lower_data) else $error("lower snapshot not read");

   c_upper_read: cover property (@(posedge clock) read_upper);
   c_ordered:    cover property (@(posedge clock) read_upper ##[1:20] read_lower);
   c_irq:        cover property (@(posedge clock) interrupt);

endmodule // pbec_counter

/* hdl/pbec_pkg.sv */
/*
 * Package for the pattern bit error counter block: register offsets,
 * reset values, interrupt bit positions and the bus answer types.
 * Assumes a 32-bit Avalon-MM slave with word addressing in bytes.
 */
package pbec_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] addr_count_upper = 4'h0;
   localparam logic [3:0] addr_count_lower = 4'h4;
   localparam logic [3:0] addr_irq_status  = 4'h8;
   localparam logic [3:0] addr_irq_enable  = 4'hC;
   localparam logic [4:0] addr_irq_clear   = 5'h10;

   localparam logic [15:0] count_reset     = 16'h0000;
   localparam logic [7:0]  byte_reset      = 8'h00;
   localparam logic [1:0]  irq_reset       = 2'h0;
   localparam int          irq_error_bit   = 0;
   localparam int          irq_wrap_bit    = 1;
   localparam logic [31:0] unmapped_data   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Bus types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [31:0] writedata;
   } pbec_request_type;

   typedef enum logic [2:0] {
      pbec_idle   = 3'b001,
      pbec_answer = 3'b010,
      pbec_done   = 3'b100
   } pbec_state_type;

endpackage

/* testbench/prbs_bit_error_counter_tb.sv */
/*
 * Self-checking bench for the pattern bit error counter.
 * Assumes the design package and pbec_counter are compiled before it.
 */
`timescale 1ns/10ps
module prbs_bit_error_counter_tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [4:0] up = {1'b0, pbec_pkg::addr_count_upper};
   localparam logic [4:0] lo = {1'b0, pbec_pkg::addr_count_lower};
   localparam logic [4:0] st = {1'b0, pbec_pkg::addr_irq_status};
   localparam logic [4:0] en = {1'b0, pbec_pkg::addr_irq_enable};
   localparam logic [4:0] cl = pbec_pkg::addr_irq_clear;
   logic        clock;
   logic        rst;
   logic        pattern_error;
   logic        read;
   logic        write;
   logic [4:0]  address;
   logic [31:0] writedata;
   logic [31:0] readdata;
   logic        waitrequest;
   logic        interrupt;
   logic [31:0] expect_q[$];
   integer      seed;
   int          bad_count;
   int          comparisons;
   logic [15:0] n;

   pbec_counter pbec_counter_i (
      .clock         (clock),
      .rst           (rst),
      .pattern_error (pattern_error),
      .read          (read),
      .write         (write),
      .address       (address),
      .writedata     (writedata),
      .readdata      (readdata),
      .waitrequest   (waitrequest),
      .interrupt     (interrupt)
   );

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ----------------------------------------------------------------
   // Checking
   // ----------------------------------------------------------------
   task automatic wrap_up;
      // A read whose answer never came leaves its note behind.
      if (expect_q.size() != 0)
         bad_count++;
      if (bad_count == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic compare_word(input logic [31:0] got, input logic [31:0] want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("unexpected read at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   task automatic compare_irq(input logic got, input logic want);
      comparisons++;
      if (got !== want) begin
         bad_count++;
         $display("unexpected interrupt at %0t: got %h expected %h", $time, got, want);
      end
   endtask

   // Read data stand only at the edge that sees waitrequest low.
   always @(posedge clock) begin
      if (read === 1'b1 && waitrequest === 1'b0) begin
         if (expect_q.size() == 0)
            compare_word(readdata, 32'hFFFF_FFFF);
         else
            compare_word(readdata, expect_q.pop_front());
      end
   end

   // ----------------------------------------------------------------
   // Bus and event drivers
   // ----------------------------------------------------------------
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      read <= ~wr;
      write <= wr;
      address <= a;
      writedata <= d;
      // Only the watchdog ends a wait that never gets its answer.
      do begin
         @(posedge clock);
      end while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
      // An idle edge keeps the next request from landing in this time step.
      @(posedge clock);
   endtask

   task automatic rd(input logic [4:0] a, input logic [31:0] want);
      expect_q.push_back(want);
      bus(1'b0, a, 32'h0000_0000);
   endtask

   task automatic errs(input int cnt);
      int   k;
      logic b;
      k = 0;
      while (k < cnt) begin
         b = 1'($random(seed));
         pattern_error <= b;
         k += int'(b);
         @(posedge clock);
      end
      pattern_error <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   initial begin
      seed = 7;
      bad_count = 0;
      comparisons = 0;
      rst = 1'b1;
      pattern_error = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0000_0000;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      rd(up, 32'h0000_0000);
      rd(lo, 32'h0000_0000);
      rd(5'h14, pbec_pkg::unmapped_data);
      for (int i = 0; i < 3; i++) begin
         n = 16'($random(seed)) & 16'h03FF;
         errs(int'(n));
         rd(up, {24'h000000, n[15:8]});
         rd(lo, {24'h000000, n[7:0]});
      end
      errs(291);
      rd(up, 32'h0000_0001);
      errs(5);
      rd(lo, 32'h0000_0023);
      rd(up, 32'h0000_0000);
      rd(lo, 32'h0000_0005);
      rd(up, 32'h0000_0000);
      rd(lo, 32'h0000_0000);
      errs(300);
      rd(lo, 32'h0000_002C);
      rd(up, 32'h0000_0001);
      rd(lo, 32'h0000_0000);
      errs(3);
      bus(1'b1, up, 32'h0000_00FF);
      rd(up, 32'h0000_0000);
      rd(lo, 32'h0000_0003);
      bus(1'b1, cl, 32'h0000_0001);
      rd(st, 32'h0000_0000);
      errs(2);
      repeat (2) @(posedge clock);
      compare_irq(interrupt, 1'b0);
      rd(st, 32'h0000_0001);
      bus(1'b1, en, 32'h0000_0001);
      repeat (2) @(posedge clock);
      compare_irq(interrupt, 1'b1);
      bus(1'b1, cl, 32'h0000_0001);
      repeat (2) @(posedge clock);
      compare_irq(interrupt, 1'b0);
      rd(en, 32'h0000_0001);
      rd(up, 32'h0000_0000);
      rd(lo, 32'h0000_0002);
      // One error more than full scale: the count must stick at its top.
      pattern_error <= 1'b1;
      repeat (65536) @(posedge clock);
      pattern_error <= 1'b0;
      rd(st, 32'h0000_0003);
      rd(up, 32'h0000_00FF);
      rd(lo, 32'h0000_00FF);
      wrap_up;
   end

   initial begin
      #(40 * 90000);
      bad_count++;
      wrap_up;
   end
endmodule // prbs_bit_error_counter_tb
